// File: ipe_defs.vh
// Constants of the interrupt priority and enable register bank.
// Assumes inclusion by ipe_regs.v only; definitions only.
`ifndef IPE_DEFS_VH
`define IPE_DEFS_VH

// Register indexes; byte address is four times the index
`define IPE_IDX_PRIO_KT 16'hff20
`define IPE_IDX_PRIO_NSCD 16'hff21
`define IPE_IDX_EN_KEYS 16'hff23
`define IPE_IDX_EN_TS 16'hff24
`define IPE_IDX_EN_CD 16'hff25
`define IPE_IDX_FLAG_KEYS 16'hff27
`define IPE_IDX_FLAG_TS 16'hff28
`define IPE_IDX_FLAG_CD 16'hff29

// Internal register slots
`define IPE_SLOT_PRIO_KT 4'h0
`define IPE_SLOT_PRIO_NSCD 4'h1
`define IPE_SLOT_EN_KEYS 4'h2
`define IPE_SLOT_EN_TS 4'h3
`define IPE_SLOT_EN_CD 4'h4
`define IPE_SLOT_FLAG_KEYS 4'h5
`define IPE_SLOT_FLAG_TS 4'h6
`define IPE_SLOT_FLAG_CD 4'h7
`define IPE_SLOT_NONE 4'hf

// Implemented bits of each register
`define IPE_MASK_PRIO 8'hff
`define IPE_MASK_KEYS 8'hf8
`define IPE_MASK_TS 8'hff
`define IPE_MASK_CD 8'hfc

// Reset value of every register
`define IPE_RST_VAL 8'h00

// Priority field positions (lsb of each pair)
`define IPE_POS_KEYHI 6
`define IPE_POS_KEYLO 4
`define IPE_POS_WIDE_B 2
`define IPE_POS_WIDE_A 0
`define IPE_POS_NARROW 6
`define IPE_POS_SERIAL 4
`define IPE_POS_CLOCK 2
`define IPE_POS_DISPLAY 0

// AXI responses
`define IPE_RESP_OKAY 2'b00
`define IPE_RESP_SLVERR 2'b10

`endif

// File: ipe_evt_src.sv
// Model of the peripherals that raise interrupt causes.
// Assumes a one-cycle fire from the bench; pulse comes lag plus one cycles after fire is sampled.
`timescale 1ns/100ps
module ipe_evt_src (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench command
   input wire logic fire,
   input wire logic [3:0] lag,
   input wire logic [18:0] pat,
   // Cause pulses
   output logic [4:0] key_evt,
   output logic [7:0] timer_serial_evt,
   output logic [5:0] clock_display_evt
);
   logic [18:0] pend_r;
   logic [18:0] evt_r;
   logic [3:0] cnt_r;
   logic arm_r;
   assign {key_evt, timer_serial_evt, clock_display_evt} = evt_r;
   always @(posedge aclk) begin
      evt_r <= 19'h0;
      if (!aresetn) begin
         arm_r <= 1'b0;
      end else if (fire) begin
         arm_r <= 1'b1;
         cnt_r <= lag;
         pend_r <= pat;
      end else if (arm_r && cnt_r == 4'h0) begin
         evt_r <= pend_r;
         arm_r <= 1'b0;
      end else if (arm_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule

// File: ipe_regs.v
// Interrupt priority, enable and factor flag registers behind AXI4-Lite.
// Assumes event inputs are one-cycle pulses from logic on aclk.
//
// What this block does
// R1: Second priority register: narrow timer, serial, clock timer, display, two bits each.
// R2: First priority register: key high, key low, wide timer b, wide timer a.
// R3: Key enable bits 7..4 enable key lines 3..0 individually.
// R4: Key enable bit 3 enables the whole low key group together.
// R5: Timer enable bits 6..3: timer b match, b underflow, a match, a underflow.
// R6: Timer enable bit 7 enables the narrow timer underflow interrupt.
// R7: Serial enables: transmit done bit 2, receive done 1, receive error 0.
// R8: Clock timer enables: minute 7, 1 Hz 6, 2 Hz 5, 8 Hz 4, 32 Hz 3.
// R9: Clock timer register bit 2 enables the display interrupt.
// R10: Events set flags; writing one clears a flag; enables gate flags to the core.
// R11: Reset clears all bits; unimplemented bits ignore writes and read zero.
// R12: Request only for set flag with enable, carrying its group priority level.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "ipe_defs.vh"

module ipe_regs #(
   parameter AW = 18
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [AW-1:0] awaddr,
   input wire awvalid,
   output reg awready_r,
   // AXI4-Lite write data
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready_r,
   // AXI4-Lite write response
   output reg [1:0] bresp_r,
   output reg bvalid_r,
   input wire bready,
   // AXI4-Lite read address
   input wire [AW-1:0] araddr,
   input wire arvalid,
   output reg arready_r,
   // AXI4-Lite read data
   output reg [31:0] rdata_r,
   output reg [1:0] rresp_r,
   output reg rvalid_r,
   input wire rready,
   // Interrupt events, one-cycle pulses
   input wire [4:0] key_evt,
   input wire [7:0] timer_serial_evt,
   input wire [5:0] clock_display_evt,
   // Requests toward the core
   output reg [7:0] grp_req_r,
   output reg [15:0] grp_level_r,
   output reg irq_req_r,
   output reg [1:0] irq_level_r
);

   // Index to register slot
   function [3:0] ipe_slot;
      input [15:0] idx;
      begin
         case (idx)
            `IPE_IDX_PRIO_KT: ipe_slot = `IPE_SLOT_PRIO_KT;
            `IPE_IDX_PRIO_NSCD: ipe_slot = `IPE_SLOT_PRIO_NSCD;
            `IPE_IDX_EN_KEYS: ipe_slot = `IPE_SLOT_EN_KEYS;
            `IPE_IDX_EN_TS: ipe_slot = `IPE_SLOT_EN_TS;
            `IPE_IDX_EN_CD: ipe_slot = `IPE_SLOT_EN_CD;
            `IPE_IDX_FLAG_KEYS: ipe_slot = `IPE_SLOT_FLAG_KEYS;
            `IPE_IDX_FLAG_TS: ipe_slot = `IPE_SLOT_FLAG_TS;
            `IPE_IDX_FLAG_CD: ipe_slot = `IPE_SLOT_FLAG_CD;
            default: ipe_slot = `IPE_SLOT_NONE;
         endcase
      end
   endfunction

   // Held write address and data
   reg [AW-1:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;

   // Register bank
   reg [7:0] priority_keys_timers16_r;
   reg [7:0] priority_timer8_serial_clock_display_r;
   reg [7:0] enable_keys_r;
   reg [7:0] enable_timers_serial_r;
   reg [7:0] enable_clock_timer_display_r;
   reg [7:0] flag_r [0:2];

   wire [3:0] wslot;
   wire [3:0] rslot;
   wire do_wr;
   wire wr_lane;
   wire [7:0] wbyte;
   wire [2:0] fsel;
   wire [7:0] evt_vec [0:2];
   wire [7:0] fmask [0:2];
   wire [7:0] grp_req;
   wire [15:0] grp_level;
   reg [7:0] rbyte;
   reg any_req;
   reg [1:0] top_level;
   integer g;

   assign wslot = ipe_slot(aw_addr_r[AW-1:2]);
   assign rslot = ipe_slot(araddr[AW-1:2]);
   // Both halves of a write held and no response pending
   assign do_wr = ~awready_r & ~wready_r & ~bvalid_r;
   assign wr_lane = do_wr & w_strb_r[0];
   assign wbyte = w_data_r[7:0];

   // Named fields of the first priority register
   wire keyhi_prio_msb = priority_keys_timers16_r[7];
   wire keyhi_prio_lsb = priority_keys_timers16_r[6];
   wire keylo_prio_msb = priority_keys_timers16_r[5];
   wire keylo_prio_lsb = priority_keys_timers16_r[4];
   wire wide_timer_b_prio_msb = priority_keys_timers16_r[3];
   wire wide_timer_b_prio_lsb = priority_keys_timers16_r[2];
   wire wide_timer_a_prio_msb = priority_keys_timers16_r[1];
   wire wide_timer_a_prio_lsb = priority_keys_timers16_r[0];

   // Named fields of the second priority register
   wire narrow_timer_prio_msb = priority_timer8_serial_clock_display_r[7];
   wire narrow_timer_prio_lsb = priority_timer8_serial_clock_display_r[6];
   wire serial_prio_msb = priority_timer8_serial_clock_display_r[5];
   wire serial_prio_lsb = priority_timer8_serial_clock_display_r[4];
   wire clock_timer_prio_msb = priority_timer8_serial_clock_display_r[3];
   wire clock_timer_prio_lsb = priority_timer8_serial_clock_display_r[2];
   wire display_prio_msb = priority_timer8_serial_clock_display_r[1];
   wire display_prio_lsb = priority_timer8_serial_clock_display_r[0];

   // Named enables
   wire key_line3_en = enable_keys_r[7];
   wire key_line2_en = enable_keys_r[6];
   wire key_line1_en = enable_keys_r[5];
   wire key_line0_en = enable_keys_r[4];
   wire key_group_low_en = enable_keys_r[3];
   wire narrow_timer_underflow_en = enable_timers_serial_r[7];
   wire wide_timer_b_match_en = enable_timers_serial_r[6];
   wire wide_timer_b_underflow_en = enable_timers_serial_r[5];
   wire wide_timer_a_match_en = enable_timers_serial_r[4];
   wire wide_timer_a_underflow_en = enable_timers_serial_r[3];
   wire serial_tx_done_en = enable_timers_serial_r[2];
   wire serial_rx_done_en = enable_timers_serial_r[1];
   wire serial_rx_error_en = enable_timers_serial_r[0];
   wire minute_tick_en = enable_clock_timer_display_r[7];
   wire tick_1hz_en = enable_clock_timer_display_r[6];
   wire tick_2hz_en = enable_clock_timer_display_r[5];
   wire tick_8hz_en = enable_clock_timer_display_r[4];
   wire tick_32hz_en = enable_clock_timer_display_r[3];
   wire display_irq_en = enable_clock_timer_display_r[2];

   // Named flags
   wire key_line3_flag = flag_r[0][7];
   wire [3:0] key_hi_flags = {key_line3_flag, flag_r[0][6:4]};
   wire key_lo_flag = flag_r[0][3];

   // Write address channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         aw_addr_r <= {AW{1'b0}};
      end else if (awvalid && awready_r) begin
         awready_r <= 1'b0;
         aw_addr_r <= awaddr;
      end else if (bvalid_r && bready) begin
         awready_r <= 1'b1;
      end
   end

   // Write data channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         wready_r <= 1'b1;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (wvalid && wready_r) begin
         wready_r <= 1'b0;
         w_data_r <= wdata;
         w_strb_r <= wstrb;
      end else if (bvalid_r && bready) begin
         wready_r <= 1'b1;
      end
   end

   // Write response
   always @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `IPE_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         if (wslot == `IPE_SLOT_NONE) begin
            bresp_r <= `IPE_RESP_SLVERR;
         end else begin
            bresp_r <= `IPE_RESP_OKAY;
         end
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Priority and enable registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         priority_keys_timers16_r <= `IPE_RST_VAL; // see R11
         priority_timer8_serial_clock_display_r <= `IPE_RST_VAL; // see R11
         enable_keys_r <= `IPE_RST_VAL; // see R11
         enable_timers_serial_r <= `IPE_RST_VAL; // see R11
         enable_clock_timer_display_r <= `IPE_RST_VAL; // see R11
      end else if (wr_lane) begin
         case (wslot)
            `IPE_SLOT_PRIO_KT: begin
               priority_keys_timers16_r <= wbyte & `IPE_MASK_PRIO; // see R2
            end
            `IPE_SLOT_PRIO_NSCD: begin
               priority_timer8_serial_clock_display_r <= wbyte & `IPE_MASK_PRIO; // see R1
            end
            `IPE_SLOT_EN_KEYS: begin
               // Unused low bits dropped
               enable_keys_r <= wbyte & `IPE_MASK_KEYS; // see R3 see R4 see R11
            end
            `IPE_SLOT_EN_TS: begin
               enable_timers_serial_r <= wbyte & `IPE_MASK_TS; // see R5 see R6 see R7
            end
            `IPE_SLOT_EN_CD: begin
               enable_clock_timer_display_r <= wbyte & `IPE_MASK_CD; // see R8 see R9 see R11
            end
            default: begin
            end
         endcase
      end
   end

   // Factor flags: set wins over a clear in the same cycle
   assign fsel = {wslot == `IPE_SLOT_FLAG_CD, wslot == `IPE_SLOT_FLAG_TS,
                  wslot == `IPE_SLOT_FLAG_KEYS};
   assign evt_vec[0] = {key_evt, 3'b000};
   assign evt_vec[1] = timer_serial_evt;
   assign evt_vec[2] = {clock_display_evt, 2'b00};
   assign fmask[0] = `IPE_MASK_KEYS;
   assign fmask[1] = `IPE_MASK_TS;
   assign fmask[2] = `IPE_MASK_CD;

   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_flag
         wire [7:0] clr = (wr_lane && fsel[i]) ? wbyte : 8'h00;
         always @(posedge aclk) begin
            if (!aresetn) begin
               flag_r[i] <= `IPE_RST_VAL;
            end else begin
               // Writing one clears, zero leaves alone
               flag_r[i] <= (evt_vec[i] | (flag_r[i] & ~clr)) & fmask[i]; // see R10
            end
         end
      end
   endgenerate

   // Read mux; unimplemented bits are held at zero
   always @* begin
      case (rslot)
         `IPE_SLOT_PRIO_KT: rbyte = priority_keys_timers16_r;
         `IPE_SLOT_PRIO_NSCD: rbyte = priority_timer8_serial_clock_display_r;
         `IPE_SLOT_EN_KEYS: rbyte = enable_keys_r;
         `IPE_SLOT_EN_TS: rbyte = enable_timers_serial_r;
         `IPE_SLOT_EN_CD: rbyte = enable_clock_timer_display_r;
         `IPE_SLOT_FLAG_KEYS: rbyte = flag_r[0];
         `IPE_SLOT_FLAG_TS: rbyte = flag_r[1];
         `IPE_SLOT_FLAG_CD: rbyte = flag_r[2];
         default: rbyte = 8'h00;
      endcase
   end

   // Read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `IPE_RESP_OKAY;
      end else if (arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= {24'h00_0000, rbyte}; // see R11
         if (rslot == `IPE_SLOT_NONE) begin
            rresp_r <= `IPE_RESP_SLVERR;
         end else begin
            rresp_r <= `IPE_RESP_OKAY;
         end
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // Group requests: flag and enable both set
   assign grp_req[7] = |(key_hi_flags &
                         {key_line3_en, key_line2_en, key_line1_en, key_line0_en}); // see R12
   assign grp_req[6] = key_lo_flag & key_group_low_en; // see R12
   assign grp_req[5] = |(flag_r[1][6:5] & {wide_timer_b_match_en, wide_timer_b_underflow_en});
   assign grp_req[4] = |(flag_r[1][4:3] & {wide_timer_a_match_en, wide_timer_a_underflow_en});
   assign grp_req[3] = flag_r[1][7] & narrow_timer_underflow_en;
   assign grp_req[2] = |(flag_r[1][2:0] &
                         {serial_tx_done_en, serial_rx_done_en, serial_rx_error_en});
   assign grp_req[1] = |(flag_r[2][7:3] &
                         {minute_tick_en, tick_1hz_en, tick_2hz_en, tick_8hz_en, tick_32hz_en});
   assign grp_req[0] = flag_r[2][2] & display_irq_en;

   // Group levels, eleven is level 3 down to 00 as level 0
   assign grp_level[15:14] = {keyhi_prio_msb, keyhi_prio_lsb}; // see R2
   assign grp_level[13:12] = {keylo_prio_msb, keylo_prio_lsb};
   assign grp_level[11:10] = {wide_timer_b_prio_msb, wide_timer_b_prio_lsb};
   assign grp_level[9:8] = {wide_timer_a_prio_msb, wide_timer_a_prio_lsb};
   assign grp_level[7:6] = {narrow_timer_prio_msb, narrow_timer_prio_lsb}; // see R1
   assign grp_level[5:4] = {serial_prio_msb, serial_prio_lsb};
   assign grp_level[3:2] = {clock_timer_prio_msb, clock_timer_prio_lsb};
   assign grp_level[1:0] = {display_prio_msb, display_prio_lsb};

   // Highest level among requesting groups
   always @* begin
      any_req = 1'b0;
      top_level = 2'b00;
      for (g = 0; g < 8; g = g + 1) begin
         if (grp_req[g]) begin
            if (!any_req || grp_level[2*g +: 2] > top_level) begin
               top_level = grp_level[2*g +: 2]; // see R12
            end
            any_req = 1'b1;
         end
      end
   end

   // Registered request outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         grp_req_r <= 8'h00;
         grp_level_r <= 16'h0000;
         irq_req_r <= 1'b0;
         irq_level_r <= 2'b00;
      end else begin
         grp_req_r <= grp_req; // see R10 see R12
         grp_level_r <= grp_level;
         irq_req_r <= any_req;
         irq_level_r <= top_level;
      end
   end

endmodule

// File: ipe_regs_checker.sv
// Assertions on the bus and request ports of the register bank.
// Assumes binding into ipe_regs; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module ipe_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready_r,
   input wire logic wvalid,
   input wire logic wready_r,
   input wire logic [1:0] bresp_r,
   input wire logic bvalid_r,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready_r,
   input wire logic [31:0] rdata_r,
   input wire logic [1:0] rresp_r,
   input wire logic rvalid_r,
   input wire logic rready,
   // Requests
   input wire logic [7:0] grp_req_r,
   input wire logic [15:0] grp_level_r,
   input wire logic irq_req_r,
   input wire logic [1:0] irq_level_r
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_rd_answer;
      arvalid && arready_r |=> rvalid_r && !arready_r;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_wr_answer;
      awvalid && awready_r && wvalid && wready_r |-> ##2 bvalid_r;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_b_hold;
      bvalid_r && !bready |=> bvalid_r && $stable(bresp_r);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      rvalid_r && !rready |=> rvalid_r && $stable(rdata_r);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_rd_upper;
      rvalid_r |-> rdata_r[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper data set");
   property p_any_req;
      irq_req_r == (|grp_req_r);
   endproperty
   a_any_req: assert property (p_any_req) else $error("summary mismatch");
   property p_idle_lvl;
      !irq_req_r |-> irq_level_r == 2'h0;
   endproperty
   a_idle_lvl: assert property (p_idle_lvl) else $error("idle level");
   property p_top_lvl;
      grp_req_r[7] |-> irq_level_r >= grp_level_r[15:14];
   endproperty
   a_top_lvl: assert property (p_top_lvl) else $error("key level low");
   property p_low_lvl;
      grp_req_r[0] |-> irq_level_r >= grp_level_r[1:0];
   endproperty
   a_low_lvl: assert property (p_low_lvl) else $error("display level low");
   property p_req_fall;
      $past(aresetn) && |($past(grp_req_r) & ~grp_req_r) |-> $past(bvalid_r);
   endproperty
   a_req_fall: assert property (p_req_fall) else $error("request lost");
   c_write: cover property (bvalid_r && bready);
   c_slverr: cover property (rvalid_r && rresp_r == 2'b10);
   c_req: cover property ($rose(irq_req_r));
endmodule
bind ipe_regs ipe_checker chk_u (.*);

// File: ipe_regs_test.sv
// Self-checking bench for the register bank.
// Assumes ipe_regs, ipe_evt_src and the bound checker.
`timescale 1ns/100ps
module ipe_regs_test;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire;
   logic [17:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb, lag;
   logic [18:0] pat;
   wire awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_req_r;
   wire [1:0] bresp_r, rresp_r, irq_level_r;
   wire [31:0] rdata_r;
   wire [7:0] grp_req_r, timer_serial_evt;
   wire [15:0] grp_level_r;
   wire [4:0] key_evt;
   wire [5:0] clock_display_evt;
   int err_count = 0;
   int checked = 0;
   int i;
   logic [33:0] rows [0:5];
   ipe_regs dut_u (.*);
   ipe_evt_src src_u (.*);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic wrap_up;
      if (err_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready_r) awvalid <= 1'b0;
         if (wready_r) wvalid <= 1'b0;
      end while (!bvalid_r && n < 64);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp_r});
      if (n == 64) chk("write wait", 32'h1, 32'h0);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready_r) arvalid <= 1'b0;
      end while (!rvalid_r && n < 64);
      rready <= 1'b0;
      chk("rdata", {24'h0, d}, rdata_r);
      chk("rresp", {30'h0, er}, {30'h0, rresp_r});
      if (n == 64) chk("read wait", 32'h1, 32'h0);
   endtask
   task automatic pulse(input logic [18:0] p, input logic [3:0] l);
      @(posedge aclk);
      fire <= 1'b1;
      pat <= p;
      lag <= l;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (l + 4) @(posedge aclk);
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = 7'h0;
      {awaddr, araddr, wdata, lag, pat} = 91'h0;
      wstrb = 4'hf;
      rows[0] = {16'hff20, 8'hff, 8'hff, 2'b00};
      rows[1] = {16'hff21, 8'ha5, 8'ha5, 2'b00};
      rows[2] = {16'hff23, 8'hff, 8'hf8, 2'b00};
      rows[3] = {16'hff24, 8'hff, 8'hff, 2'b00};
      rows[4] = {16'hff25, 8'hff, 8'hfc, 2'b00};
      rows[5] = {16'hff22, 8'hff, 8'h00, 2'b10};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++) rd(rows[i][33:18], 8'h00, rows[i][1:0]);
      for (i = 0; i < 6; i++) begin
         wr(rows[i][33:18], rows[i][17:10], rows[i][1:0]);
         rd(rows[i][33:18], rows[i][9:2], rows[i][1:0]);
      end
      // Every cause at once, slow partner
      pulse(19'h7ffff, 4'h5);
      rd(16'hff27, 8'hf8, 2'b00);
      rd(16'hff28, 8'hff, 2'b00);
      rd(16'hff29, 8'hfc, 2'b00);
      chk("grp_req", 32'hff, {24'h0, grp_req_r});
      chk("irq_level", 32'h3, {30'h0, irq_level_r});
      chk("grp_level", 32'hffa5, {16'h0, grp_level_r});
      wr(16'hff28, 8'h00, 2'b00);
      rd(16'hff28, 8'hff, 2'b00);
      wr(16'hff27, 8'hff, 2'b00);
      rd(16'hff27, 8'h00, 2'b00);
      wr(16'hff24, 8'h00, 2'b00);
      repeat (2) @(posedge aclk);
      chk("grp_req", 32'h03, {24'h0, grp_req_r});
      chk("irq_level", 32'h1, {30'h0, irq_level_r});
      // Key line 3 and low key group, prompt partner
      pulse(19'h44000, 4'h0);
      chk("grp_req", 32'hc3, {24'h0, grp_req_r});
      chk("irq_level", 32'h3, {30'h0, irq_level_r});
      // Clear lands with a new key line 3 event: set wins
      fork
         pulse(19'h40000, 4'h0);
         begin
            @(posedge aclk);
            wr(16'hff27, 8'h88, 2'b00);
         end
      join
      rd(16'hff27, 8'h80, 2'b00);
      chk("grp_req", 32'h83, {24'h0, grp_req_r});
      // Write with lane 0 off changes nothing
      wstrb <= 4'h0;
      wr(16'hff20, 8'h00, 2'b00);
      wstrb <= 4'hf;
      rd(16'hff20, 8'hff, 2'b00);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(16'hff20, 8'h00, 2'b00);
      rd(16'hff27, 8'h00, 2'b00);
      chk("grp_req", 32'h0, {24'h0, grp_req_r});
      wrap_up;
   end
   initial begin
      #200000;
      err_count++;
      wrap_up;
   end
endmodule
